// ==== src/nvmacc_pkg.sv ====
/*
  Shared constants and carrier types for the EEPROM access register block.
  Assumes a single 100 MHz clock and an 8-bit core register bus.
*/
package nvmacc_pkg;

  // ----------------------------------------------------------------
  // Register placement
  // ----------------------------------------------------------------
  localparam logic [7:0] LOC_REG_ADDR = 8'h2A; // Direct register, bank 0
  localparam logic [7:0] BYTE_REG_ADDR = 8'h2B; // Direct register, bank 0
  localparam logic [7:0] CTRL_REG_ADDR = 8'h40; // Indirect only
  localparam logic [7:0] CTRL_REG_BANK = 8'h01; // Bank holding the control byte

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int LOC_W = 6; // Location width, 64 cells
  localparam int DATA_W = 8; // Cell width
  localparam int DEPTH = 64; // Number of cells
  localparam int CTRL_W = 4; // Implemented control bits
  localparam int PROG_PERMIT_BIT = 3;
  localparam int PROG_TRIG_BIT = 2;
  localparam int FETCH_PERMIT_BIT = 1;
  localparam int FETCH_TRIG_BIT = 0;
  localparam logic [LOC_W-1:0] LOC_RST = 6'h00;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FETCH_TIME_NS = 20; // Array read time
  localparam int PROG_TIME_NS = 100; // Array program time
  localparam int FETCH_CYCLES = (FETCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd; // Read strobe
    logic wr; // Write strobe
    logic indirect; // Access made through the indirect port
    logic [7:0] bank; // Bank select pointer value
    logic [7:0] addr; // Direct address or pointer value
    logic [7:0] wdata; // Write data
  } nvmacc_req_t;

  typedef enum logic [1:0] {
    NVMACC_IDLE = 2'b00,
    NVMACC_FETCH = 2'b01,
    NVMACC_PROG = 2'b10
  } nvmacc_state_t;

endpackage

// ==== src/nvmacc_array.sv ====
/*
  EEPROM cell array model: 64 bytes of flip-flops with fixed fetch and program busy times.
  Assumes start_i is a one-cycle pulse given only while idle.
*/
`timescale 1ns/1ns
`default_nettype none
module nvmacc_array
  import nvmacc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic prog_i,
  input wire logic [LOC_W-1:0] loc_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic done_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem_ff [DEPTH]; // Cells, not reset: contents persist
  logic busy_ff, nxt_busy;
  logic prog_ff, nxt_prog;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [LOC_W-1:0] loc_ff, nxt_loc;
  logic [DATA_W-1:0] wd_ff, nxt_wd;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic done_ff, nxt_done;
  logic finish; // Last busy cycle

  // Sequencer next state
  always_comb begin
    finish = busy_ff && (cnt_ff == '0);
    nxt_busy = busy_ff;
    nxt_prog = prog_ff;
    nxt_cnt = cnt_ff;
    nxt_loc = loc_ff;
    nxt_wd = wd_ff;
    nxt_rdata = rdata_ff;
    nxt_done = 1'b0;
    if (start_i && !busy_ff) begin
      // Latch operands so later register writes cannot disturb the cycle
      nxt_busy = 1'b1;
      nxt_prog = prog_i;
      nxt_loc = loc_i;
      nxt_wd = wdata_i;
      nxt_cnt = prog_i ? CNT_W'(PROG_CYCLES - 1) : CNT_W'(FETCH_CYCLES - 1);
    end else if (finish) begin
      nxt_busy = 1'b0;
      nxt_done = 1'b1;
      if (!prog_ff) begin
        nxt_rdata = mem_ff[loc_ff];
      end
    end else if (busy_ff) begin
      nxt_cnt = cnt_ff - CNT_W'(1);
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_ff <= 1'b0;
      prog_ff <= 1'b0;
      cnt_ff <= '0;
      loc_ff <= '0;
      wd_ff <= '0;
      rdata_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
      prog_ff <= nxt_prog;
      cnt_ff <= nxt_cnt;
      loc_ff <= nxt_loc;
      wd_ff <= nxt_wd;
      rdata_ff <= nxt_rdata;
      done_ff <= nxt_done;
    end
  end

  // Cell storage, one byte per program cycle
  always_ff @(posedge clk_i) begin
    if (finish && prog_ff) begin
      mem_ff[loc_ff] <= wd_ff;
    end
  end

  assign rdata_o = rdata_ff;
  assign done_o = done_ff;

endmodule
`default_nettype wire

// ==== src/nvmacc_regs.sv ====
/*
  EEPROM access registers: location, byte and control, on the core register bus.
  Assumes one request per cycle, strobes synchronous to clk_i, and that the core
  marks accesses made through its indirect port with the pointer and bank values.
*/
`timescale 1ns/1ns
`default_nettype none
module nvmacc_regs
  import nvmacc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire nvmacc_req_t req_i,
  output logic [7:0] rdata_o,
  output logic busy_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [LOC_W-1:0] loc_ff, nxt_loc; // Location register
  logic [DATA_W-1:0] byte_ff, nxt_byte; // Byte register
  logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl; // Control register
  nvmacc_state_t state_ff, nxt_state;
  logic [7:0] rdata_ff, nxt_rdata;
  logic busy_ff, nxt_busy;
  logic sel_loc, sel_byte, sel_ctrl; // Decoded selects
  logic start, start_prog; // Launch pulse to the array
  logic [DATA_W-1:0] arr_rdata;
  logic arr_done;

  // Control byte match: pointer and bank as software must set them
  function automatic logic hit_ctrl(input nvmacc_req_t r);
    hit_ctrl = r.indirect && (r.addr == CTRL_REG_ADDR) && (r.bank == CTRL_REG_BANK);
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    sel_loc = 1'b0;
    sel_byte = 1'b0;
    sel_ctrl = 1'b0;
    if (hit_ctrl(req_i)) begin
      sel_ctrl = 1'b1;
    end else if (!req_i.indirect && (req_i.addr == LOC_REG_ADDR)) begin
      sel_loc = 1'b1;
    end else if (!req_i.indirect && (req_i.addr == BYTE_REG_ADDR)) begin
      sel_byte = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register and sequencer next values
  // ----------------------------------------------------------------
  always_comb begin
    nxt_loc = loc_ff;
    nxt_byte = byte_ff;
    nxt_ctrl = ctrl_ff;
    nxt_state = state_ff;
    start = 1'b0;
    start_prog = 1'b0;
    // Plain writes; upper location bits are simply not stored
    if (req_i.wr && sel_loc) begin
      nxt_loc = req_i.wdata[LOC_W-1:0];
    end
    if (req_i.wr && sel_byte) begin
      nxt_byte = req_i.wdata;
    end
    if (req_i.wr && sel_ctrl) begin
      // Permits always writable; bits 7-4 dropped
      nxt_ctrl[PROG_PERMIT_BIT] = req_i.wdata[PROG_PERMIT_BIT];
      nxt_ctrl[FETCH_PERMIT_BIT] = req_i.wdata[FETCH_PERMIT_BIT];
      // Triggers only move while idle, so a running cycle cannot be cancelled
      if (state_ff == NVMACC_IDLE) begin
        nxt_ctrl[PROG_TRIG_BIT] = 1'b0;
        nxt_ctrl[FETCH_TRIG_BIT] = 1'b0;
        // Program has priority when both triggers arrive together
        if (req_i.wdata[PROG_TRIG_BIT] && ctrl_ff[PROG_PERMIT_BIT]) begin
          nxt_ctrl[PROG_TRIG_BIT] = 1'b1;
          start = 1'b1;
          start_prog = 1'b1;
          nxt_state = NVMACC_PROG;
        end else if (req_i.wdata[FETCH_TRIG_BIT] && ctrl_ff[FETCH_PERMIT_BIT]) begin
          nxt_ctrl[FETCH_TRIG_BIT] = 1'b1;
          start = 1'b1;
          nxt_state = NVMACC_FETCH;
        end
      end
    end
    // Completion: one byte moved, trigger drops
    case (state_ff)
      NVMACC_FETCH: begin
        if (arr_done) begin
          nxt_byte = arr_rdata; // Hardware load beats a same-cycle software write
          nxt_ctrl[FETCH_TRIG_BIT] = 1'b0;
          nxt_state = NVMACC_IDLE;
        end
      end
      NVMACC_PROG: begin
        if (arr_done) begin
          nxt_ctrl[PROG_TRIG_BIT] = 1'b0;
          nxt_state = NVMACC_IDLE;
        end
      end
      default: begin
      end
    endcase
  end

  // Read data: registered, unimplemented bits zero, unmapped reads zero
  always_comb begin
    nxt_rdata = rdata_ff;
    if (req_i.rd) begin
      nxt_rdata = 8'h00;
      if (sel_loc) begin
        nxt_rdata = {2'b00, loc_ff};
      end else if (sel_byte) begin
        nxt_rdata = byte_ff;
      end else if (sel_ctrl) begin
        nxt_rdata = {4'h0, ctrl_ff};
      end
    end
    nxt_busy = (nxt_state != NVMACC_IDLE);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loc_ff <= LOC_RST;
      byte_ff <= BYTE_RST;
      ctrl_ff <= CTRL_RST;
      state_ff <= NVMACC_IDLE;
      rdata_ff <= 8'h00;
      busy_ff <= 1'b0;
    end else begin
      loc_ff <= nxt_loc;
      byte_ff <= nxt_byte;
      ctrl_ff <= nxt_ctrl;
      state_ff <= nxt_state;
      rdata_ff <= nxt_rdata;
      busy_ff <= nxt_busy;
    end
  end

  // ----------------------------------------------------------------
  // Cell array, reached only through these registers
  // ----------------------------------------------------------------
  nvmacc_array u_array (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(start),
    .prog_i(start_prog),
    .loc_i(loc_ff),
    .wdata_i(byte_ff),
    .rdata_o(arr_rdata),
    .done_o(arr_done)
  );

  assign rdata_o = rdata_ff;
  assign busy_o = busy_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_LOC_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.wr && sel_loc) |=> (loc_ff == $past(req_i.wdata[LOC_W-1:0])))
    else $error("Location register did not take write");
  AST_LOC_UPPER_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.rd && sel_loc) |=> (rdata_o[7:6] == 2'b00) && (rdata_o[5:0] == $past(loc_ff)))
    else $error("Location read upper bits not zero");
  AST_BYTE_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.wr && sel_byte && !(state_ff == NVMACC_FETCH && arr_done)) |=> (byte_ff == $past(req_i.wdata)))
    else $error("Byte register did not take write");
  AST_CTRL_DIRECT_IGNORED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.wr && !req_i.indirect && !arr_done) |=> $stable(ctrl_ff))
    else $error("Control register changed by direct access");
  AST_CTRL_UPPER_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.rd && sel_ctrl) |=> (rdata_o[7:4] == 4'h0) && (rdata_o[3:0] == $past(ctrl_ff)))
    else $error("Control read upper bits not zero");
  AST_START_NEEDS_PERMIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start |-> (start_prog ? ctrl_ff[PROG_PERMIT_BIT] : ctrl_ff[FETCH_PERMIT_BIT]))
    else $error("Cycle started without permit");
  AST_TRIG_SELFCLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    arr_done |=> (ctrl_ff[PROG_TRIG_BIT] == 1'b0) && (ctrl_ff[FETCH_TRIG_BIT] == 1'b0) && !busy_o)
    else $error("Trigger did not clear at completion");
  AST_CYCLE_BOUND: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start |-> ##[2:11] arr_done)
    else $error("Cycle did not complete in time");
  AST_FETCH_LOADS_BYTE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (arr_done && state_ff == NVMACC_FETCH) |=> (byte_ff == $past(arr_rdata)))
    else $error("Fetched byte not loaded");
  // Location moves only on its own write, never from array activity
  AST_LOC_STABLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(req_i.wr && sel_loc) |=> $stable(loc_ff))
    else $error("Location register changed without a write");
  // Permits follow every control write, busy or not
  AST_PERMIT_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.wr && sel_ctrl) |=> (ctrl_ff[PROG_PERMIT_BIT] == $past(req_i.wdata[PROG_PERMIT_BIT]))
      && (ctrl_ff[FETCH_PERMIT_BIT] == $past(req_i.wdata[FETCH_PERMIT_BIT])))
    else $error("Permit bits did not take write");
  // Trigger writes during a running cycle must not cancel or restart it
  AST_TRIG_HELD_BUSY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.wr && sel_ctrl && (state_ff != NVMACC_IDLE) && !arr_done) |=> $stable(ctrl_ff[PROG_TRIG_BIT])
      && $stable(ctrl_ff[FETCH_TRIG_BIT]) && busy_o)
    else $error("Trigger moved during a running cycle");
  // Trigger with no permit standing beforehand is dropped, no cycle starts
  AST_TRIG_NO_PERMIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.wr && sel_ctrl && (state_ff == NVMACC_IDLE) && (ctrl_ff[PROG_PERMIT_BIT] == 1'b0)
      && (ctrl_ff[FETCH_PERMIT_BIT] == 1'b0)) |=> (ctrl_ff[PROG_TRIG_BIT] == 1'b0)
      && (ctrl_ff[FETCH_TRIG_BIT] == 1'b0) && !busy_o)
    else $error("Trigger accepted without permit");
  // Unmapped reads, direct reads of 40H among them, return zero
  AST_UNMAPPED_READ_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.rd && !sel_loc && !sel_byte && !sel_ctrl) |=> (rdata_o == 8'h00))
    else $error("Unmapped read returned nonzero data");

endmodule
`default_nettype wire

// ==== sim/nvmacc_regs_tb.sv ====
/*
  Self-checking bench for the EEPROM access registers.
  Assumes the register bus of nvmacc_regs, a 100 MHz clock and array timing
  taken from the package constants.
*/
`timescale 1ns/1ns
`default_nettype none
module nvmacc_regs_tb
  import nvmacc_pkg::*;
;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk_i; // Core clock
  logic rst_n_i; // Async reset, active low
  nvmacc_req_t req; // Bus request to the block
  logic [7:0] rdata; // Read data
  logic busy; // Array cycle running
  int fail_count; // Mismatches
  int check_count; // Comparisons made

  nvmacc_regs uut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .req_i(req),
    .rdata_o(rdata),
    .busy_o(busy)
  );

  // ------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Whole run is a few hundred cycles, so 20000 is ample
  initial begin
    #200000;
    fail_count = fail_count + 1;
    final_report();
  end

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  function automatic nvmacc_req_t mk(input logic r, input logic w, input logic ind, input logic [7:0] a,
                                     input logic [7:0] d);
    nvmacc_req_t q;
    q = '0;
    q.rd = r;
    q.wr = w;
    q.indirect = ind;
    q.bank = ind ? CTRL_REG_BANK : 8'h00; // Direct decode ignores the bank
    q.addr = a;
    q.wdata = d;
    return q;
  endfunction

  // Compare one 8-bit value
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One write, held for a single taking edge
  task automatic wr_reg(input logic ind, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= mk(1'b0, 1'b1, ind, a, d);
    @(posedge clk_i);
    req <= '0;
  endtask

  // One write with an explicit bank pointer value, held for a single taking edge
  task automatic wr_bank(input logic ind, input logic [7:0] b, input logic [7:0] a, input logic [7:0] d);
    nvmacc_req_t q;
    q = mk(1'b0, 1'b1, ind, a, d);
    q.bank = b;
    @(posedge clk_i);
    req <= q;
    @(posedge clk_i);
    req <= '0;
  endtask

  // One read; data stands from the taking edge on
  task automatic rd_chk(input string name, input logic ind, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    req <= mk(1'b1, 1'b0, ind, a, 8'h00);
    @(posedge clk_i);
    req <= '0;
    #1;
    chk(name, exp, rdata);
  endtask

  // Control byte through the indirect port, pointer 40H and bank 01H
  task automatic wr_ctrl(input logic [7:0] d);
    wr_reg(1'b1, CTRL_REG_ADDR, d);
  endtask

  // Wait for the array cycle to end, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 50) begin
      @(posedge clk_i);
      #1;
      n = n + 1;
    end
    if (n >= 50) chk("busy_timeout", 8'h00, 8'h01);
  endtask

  // Full program (prog=1) or fetch (prog=0) of one cell
  task automatic nvm_op(input logic prog, input logic [7:0] loc, input logic [7:0] d);
    logic [7:0] pm;
    pm = prog ? 8'h08 : 8'h02;
    wr_reg(1'b0, LOC_REG_ADDR, loc);
    wr_reg(1'b0, BYTE_REG_ADDR, prog ? d : 8'h00);
    wr_ctrl(pm);
    wr_ctrl(pm | (pm >> 1));
    @(posedge clk_i);
    #1;
    chk("busy_start", 8'h01, {7'h00, busy});
    wait_idle();
    rd_chk("ctrl_selfclear", 1'b1, CTRL_REG_ADDR, pm);
    if (!prog) rd_chk("fetched_byte", 1'b0, BYTE_REG_ADDR, d);
  endtask

  // ------------------------------------------------------------
  // Verdict
  // ------------------------------------------------------------
  task automatic final_report();
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    fail_count = 0;
    check_count = 0;
    rst_n_i = 1'b0;
    req = '0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Reset values
    rd_chk("loc_reset", 1'b0, LOC_REG_ADDR, 8'h00);
    rd_chk("byte_reset", 1'b0, BYTE_REG_ADDR, 8'h00);
    rd_chk("ctrl_reset", 1'b1, CTRL_REG_ADDR, 8'h00);
    chk("busy_reset", 8'h00, {7'h00, busy});
    // Location drops bits 7:6, byte keeps all eight
    wr_reg(1'b0, LOC_REG_ADDR, 8'hFF);
    rd_chk("loc_mask", 1'b0, LOC_REG_ADDR, 8'h3F);
    wr_reg(1'b0, LOC_REG_ADDR, 8'hC0);
    rd_chk("loc_high_only", 1'b0, LOC_REG_ADDR, 8'h00);
    wr_reg(1'b0, BYTE_REG_ADDR, 8'hA5);
    rd_chk("byte_a5", 1'b0, BYTE_REG_ADDR, 8'hA5);
    wr_reg(1'b0, BYTE_REG_ADDR, 8'h5A);
    // Read data stands until the next read, writes do not disturb it
    #1;
    chk("rdata_stands", 8'hA5, rdata);
    rd_chk("byte_5a", 1'b0, BYTE_REG_ADDR, 8'h5A);
    // Control is unreachable directly, with a wrong bank or a wrong pointer
    wr_reg(1'b0, CTRL_REG_ADDR, 8'h0A);
    rd_chk("ctrl_direct_wr", 1'b1, CTRL_REG_ADDR, 8'h00);
    rd_chk("ctrl_direct_rd", 1'b0, CTRL_REG_ADDR, 8'h00);
    wr_bank(1'b1, 8'h00, CTRL_REG_ADDR, 8'h0A);
    rd_chk("ctrl_bank0_wr", 1'b1, CTRL_REG_ADDR, 8'h00);
    wr_bank(1'b1, CTRL_REG_BANK, 8'h41, 8'h0A);
    rd_chk("ctrl_ptr41_wr", 1'b1, CTRL_REG_ADDR, 8'h00);
    // Permit and trigger in one write: permits land, no cycle
    wr_ctrl(8'hFF);
    rd_chk("ctrl_no_start", 1'b1, CTRL_REG_ADDR, 8'h0A);
    chk("busy_no_start", 8'h00, {7'h00, busy});
    wr_ctrl(8'h00);
    // Program two cells, the top one at the boundary, then fetch both
    nvm_op(1'b1, 8'h05, 8'h3C);
    nvm_op(1'b1, 8'h3F, 8'hC3);
    wr_ctrl(8'h00);
    nvm_op(1'b0, 8'h05, 8'h3C);
    nvm_op(1'b0, 8'h3F, 8'hC3);
    // Both triggers with both permits: program wins
    wr_reg(1'b0, BYTE_REG_ADDR, 8'h69);
    wr_ctrl(8'h0A);
    wr_ctrl(8'h0F);
    rd_chk("ctrl_prog_wins", 1'b1, CTRL_REG_ADDR, 8'h0E);
    wr_ctrl(8'h0B);
    rd_chk("ctrl_busy_trig", 1'b1, CTRL_REG_ADDR, 8'h0E);
    wait_idle();
    rd_chk("ctrl_after_prog", 1'b1, CTRL_REG_ADDR, 8'h0A);
    wr_ctrl(8'h02);
    nvm_op(1'b0, 8'h3F, 8'h69);
    // Reset with permits set and no cycle running clears every register but leaves the cells
    wr_reg(1'b0, LOC_REG_ADDR, 8'h15);
    wr_ctrl(8'h0A);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk("loc_rerst", 1'b0, LOC_REG_ADDR, 8'h00);
    rd_chk("byte_rerst", 1'b0, BYTE_REG_ADDR, 8'h00);
    rd_chk("ctrl_rerst", 1'b1, CTRL_REG_ADDR, 8'h00);
    chk("busy_rerst", 8'h00, {7'h00, busy});
    nvm_op(1'b0, 8'h05, 8'h3C);
    final_report();
  end
endmodule
`default_nettype wire
